// ==== design/sbp_defines.svh ====
// constants of the sync, blank and data-width front end: register map, fields, timing
// assumes a 40 MHz dot clock; included by both ends and the package users
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH

// ------------------------------------------------------------
// direct register selects
// ------------------------------------------------------------
`define SBP_RS_HOLD 3'h1
`define SBP_RS_MASK 3'h2
`define SBP_RS_INDEX 3'h6
`define SBP_RS_DATA 3'h7

// ------------------------------------------------------------
// indexed registers and reset values
// ------------------------------------------------------------
`define SBP_IDX_OUT_CLK 8'h1b
`define SBP_IDX_GEN_CTRL 8'h1d
`define SBP_RST_OUT_CLK 8'h3e
`define SBP_RST_GEN_CTRL 8'h20
`define SBP_RST_MASK 8'hff
`define SBP_RST_BYTE 8'h00

// ------------------------------------------------------------
// fields of the general control register
// ------------------------------------------------------------
`define SBP_GC_HS_HIGH 0
`define SBP_GC_VS_HIGH 1
`define SBP_GC_LEG_SYNC_HIGH 2
`define SBP_GC_SYS_MODE 3

// ------------------------------------------------------------
// fields of the output clock register
// ------------------------------------------------------------
`define SBP_OC_DIV_LSB 0
`define SBP_OC_VIDEO_CLOCK_OUT_LSB 3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SBP_CLK_PERIOD_NS 25
`define SBP_STROBE_NS 150
`define SBP_STROBE_CYC ((`SBP_STROBE_NS + `SBP_CLK_PERIOD_NS - 1) / `SBP_CLK_PERIOD_NS)
`define SBP_RECOVER_CYC 4
`define SBP_PIPE_STAGES 4

`endif

// ==== design/sbp_device.sv ====
// palette front end: sync and blank routing, shift clock, host port, 8/6 data width
// assumes pins synchronous to clk except the host strobes, which are synchronised here
//
// Notes on behaviour
// [R1] split flag rise in blank: immediate shift pulse
// [R2] early pulse replaces first normal shift pulse
// [R3] system blank active low, blanks while low
// [R4] legacy blank active low, blanks while low
// [R5] system syncs active low, drive green sync
// [R6] system sync output polarity set by control
// [R7] legacy syncs pass unchanged, also green sync
// [R8] vertical sync delayed by pipeline, polarity rules
// [R9] legacy pixel bus is legacy pixel source
// [R10] write starts on synchronised strobe falling edge
// [R11] width select high: full 8-bit transfers
// [R12] 6-bit: shift up two, zero low bits
// [R13] holding register keeps all eight bits
// [R14] 6-bit holding read zeroes top bits
// [R15] video clock output with programmable selection
// [R16] read starts on read strobe falling edge
// [R17] horizontal sync delayed by pipeline, polarity rules
// [R18] shift clock divides dot clock, gated in blank
// [R19] reset returns to legacy mode defaults
// [R20] sync, blank and pixel share pipeline depth; dacData is registered one cycle after blank and syncs
`include "sbp_defines.svh"
`default_nettype none

module sbp_device #(
    parameter int PIPE_STAGES = `SBP_PIPE_STAGES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins toward the graphics controller
    sbp_if.dev pins,
    // analog side
    output logic blankOut,
    output logic greenSyncOut,
    output logic [7:0] dacData
);
    import sbp_pkg::*;

    // ------------------------------------------------------------
    // host port: strobe synchronisers and edge detection
    // ------------------------------------------------------------
    logic wrS1_q, wrS2_q, wrS3_q;
    logic rdS1_q, rdS2_q, rdS3_q;
    logic [7:0] index_q, genCtrl_q, outClk_q, hold_q, mask_q;
    logic [7:0] readData_q;
    logic readOe_q;
    wire wrFall = wrS3_q & ~wrS2_q;
    wire rdFall = rdS3_q & ~rdS2_q;
    wire rdRise = ~rdS3_q & rdS2_q;

    // strobes are asynchronous; first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {wrS1_q, wrS2_q, wrS3_q} <= 3'h7;
            {rdS1_q, rdS2_q, rdS3_q} <= 3'h7;
        end else begin
            wrS1_q <= pins.wrN;
            wrS2_q <= wrS1_q;
            wrS3_q <= wrS2_q;
            rdS1_q <= pins.rdN;
            rdS2_q <= rdS1_q;
            rdS3_q <= rdS2_q;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire sysMode = genCtrl_q[`SBP_GC_SYS_MODE];
    wire selIndex = pins.regSel == `SBP_RS_INDEX;
    wire selData = pins.regSel == `SBP_RS_DATA;
    wire selHold = pins.regSel == `SBP_RS_HOLD;
    wire selMask = pins.regSel == `SBP_RS_MASK;
    wire idxGen = index_q == `SBP_IDX_GEN_CTRL;
    wire idxClk = index_q == `SBP_IDX_OUT_CLK;
    // in 6-bit mode the two top bits of the holding register read as zero
    wire [7:0] holdRead = pins.widthSel8 ? hold_q : {2'h0, hold_q[5:0]}; // [R11] [R14]
    wire [7:0] dataRead = idxGen ? genCtrl_q : (idxClk ? outClk_q : 8'h00);
    wire [7:0] readMux = selHold ? holdRead :
                         selMask ? mask_q :
                         selIndex ? index_q :
                         selData ? dataRead : 8'h00;

    // writes act on the synchronised falling edge; data is held by the host meanwhile
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            index_q <= `SBP_RST_BYTE;
            genCtrl_q <= `SBP_RST_GEN_CTRL; // [R19]
            outClk_q <= `SBP_RST_OUT_CLK;
            hold_q <= `SBP_RST_BYTE;
            mask_q <= `SBP_RST_MASK;
        end else if (wrFall) begin // [R10]
            if (selIndex) index_q <= pins.dataBus;
            if (selHold) hold_q <= pins.dataBus; // [R13]
            if (selMask) mask_q <= pins.dataBus;
            if (selData && idxGen) genCtrl_q <= pins.dataBus;
            if (selData && idxClk) outClk_q <= pins.dataBus;
        end
    end

    // read data latched at the falling edge, driven until the strobe returns high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readData_q <= 8'h00;
            readOe_q <= 1'b0;
        end else if (rdFall) begin // [R16]
            readData_q <= readMux;
            readOe_q <= 1'b1;
        end else if (rdRise) begin
            readOe_q <= 1'b0;
        end
    end

    assign pins.devData = readData_q;
    assign pins.devDataOe = readOe_q;

    // ------------------------------------------------------------
    // source selection for sync, blank and pixel
    // ------------------------------------------------------------
    wire sysHsActive = ~pins.systemHsyncN; // [R5]
    wire sysVsActive = ~pins.systemVsyncN; // [R5]
    wire legSyncHigh = genCtrl_q[`SBP_GC_LEG_SYNC_HIGH];
    // legacy sync polarity is unknown to the chip, so software states it for green sync
    wire legHsActive = pins.legacyHsyncIn ~^ legSyncHigh;
    wire legVsActive = pins.legacyVsyncIn ~^ legSyncHigh;
    wire sysHsOut = genCtrl_q[`SBP_GC_HS_HIGH] ? sysHsActive : pins.systemHsyncN; // [R6]
    wire sysVsOut = genCtrl_q[`SBP_GC_VS_HIGH] ? sysVsActive : pins.systemVsyncN; // [R6]
    sbp_stage_s srcStage;
    // both modes feed the same pipe slot
    assign srcStage.blank = sysMode ? ~pins.systemBlankN : ~pins.legacyBlankN; // [R3] [R4]
    assign srcStage.hsync = sysMode ? sysHsOut : pins.legacyHsyncIn; // [R7] [R17]
    assign srcStage.vsync = sysMode ? sysVsOut : pins.legacyVsyncIn; // [R7] [R8]
    assign srcStage.greenSync = sysMode ? (sysHsActive | sysVsActive) :
                                          (legHsActive | legVsActive); // [R5] [R7]
    assign srcStage.pixel = (sysMode ? pins.systemPixelBus : pins.legacyPixelBus) & mask_q; // [R9]

    // ------------------------------------------------------------
    // pixel pipeline: one slot carries every signal through the same stages; dacData is registered one cycle later
    // ------------------------------------------------------------
    sbp_stage_s pipe_q [PIPE_STAGES];

    genvar g;
    generate
        for (g = 0; g < PIPE_STAGES; g++) begin : gStage
            // each stage takes the previous one; stage 0 takes the selected sources
            localparam int PREV = (g == 0) ? 0 : g - 1;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    pipe_q[g] <= '0;
                end else begin
                    pipe_q[g] <= (g == 0) ? srcStage : pipe_q[PREV]; // [R20]
                end
            end
        end
    endgenerate

    // 6-bit mode moves bit 5 to bit 7 and zero fills the two low bits at the mux
    wire [7:0] lastPixel = pipe_q[PIPE_STAGES - 1].pixel;
    wire [7:0] dacNext = pins.widthSel8 ? lastPixel : {lastPixel[5:0], 2'h0}; // [R11] [R12]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dacData <= 8'h00;
        end else begin
            dacData <= dacNext;
        end
    end

    assign pins.horizSyncPipelined = pipe_q[PIPE_STAGES - 1].hsync; // [R17]
    assign pins.vertSyncPipelined = pipe_q[PIPE_STAGES - 1].vsync; // [R8]
    assign greenSyncOut = pipe_q[PIPE_STAGES - 1].greenSync; // [R5]
    assign blankOut = pipe_q[PIPE_STAGES - 1].blank; // [R20]

    // ------------------------------------------------------------
    // shift clock divider, blank gating and split transfer pulse
    // ------------------------------------------------------------
    logic [7:0] divCnt_q;
    logic sclkInt_q, blankGate_q, flagPrev_q, early_q, skipFirst_q, dotHalf_q;
    logic [7:0] earlyCnt_q;
    wire [1:0] divCode = outClk_q[`SBP_OC_DIV_LSB +: 2];
    wire [7:0] halfLast = 8'((8'h01 << divCode) - 8'h01);
    wire divWrap = divCnt_q == halfLast;
    wire sclkRiseNext = divWrap & ~sclkInt_q;
    wire flagRise = pins.splitTransferFlag & ~flagPrev_q;
    // the first normal pulse after a split pulse is swallowed, keeping the pulse count
    wire swallow = skipFirst_q & ~blankOut;

    // internal shift clock keeps running through blank
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q <= 8'h00;
            sclkInt_q <= 1'b0;
            dotHalf_q <= 1'b0;
        end else begin
            divCnt_q <= divWrap ? 8'h00 : 8'(divCnt_q + 8'h01); // [R18]
            sclkInt_q <= divWrap ? ~sclkInt_q : sclkInt_q; // [R18]
            dotHalf_q <= ~dotHalf_q;
        end
    end

    // blank takes effect only on a shift clock rising boundary
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blankGate_q <= 1'b0;
            flagPrev_q <= 1'b0;
            early_q <= 1'b0;
            earlyCnt_q <= 8'h00;
            skipFirst_q <= 1'b0;
        end else begin
            flagPrev_q <= pins.splitTransferFlag;
            if (sclkRiseNext) blankGate_q <= blankOut; // [R18]
            if (blankGate_q && flagRise && !early_q) begin
                early_q <= 1'b1; // [R1]
                earlyCnt_q <= halfLast;
                skipFirst_q <= 1'b1; // [R2]
            end else if (early_q) begin
                early_q <= earlyCnt_q != 8'h00;
                earlyCnt_q <= 8'(earlyCnt_q - 8'h01);
            end else if (swallow && sclkRiseNext) begin
                skipFirst_q <= 1'b0; // [R2]
            end
        end
    end

    // suppressed pulse covers the whole high half that starts at the swallowed rise
    logic swallowHigh_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            swallowHigh_q <= 1'b0;
        end else if (sclkRiseNext) begin
            swallowHigh_q <= swallow; // [R2]
        end
    end

    assign pins.shiftClockOut = early_q | (sclkInt_q & ~blankGate_q & ~swallowHigh_q); // [R1] [R18]
    assign pins.refClockOut = sclkInt_q;

    // ------------------------------------------------------------
    // video clock selection
    // ------------------------------------------------------------
    wire [1:0] vclkSel = outClk_q[`SBP_OC_VIDEO_CLOCK_OUT_LSB +: 2];
    // codes 2 and 3 hold it low so an unused pin stays quiet after reset
    assign pins.videoClockOut = (vclkSel == 2'h0) ? sclkInt_q :
                                (vclkSel == 2'h1) ? dotHalf_q : 1'b0; // [R15]
endmodule

`default_nettype wire

// ==== design/sbp_host.sv ====
// graphics controller end: drives timing pins and runs host register cycles
// assumes one request at a time from its user and the device end on the same interface
`include "sbp_defines.svh"
`default_nettype none

module sbp_host #(
    parameter int STROBE_CYC = `SBP_STROBE_CYC,
    parameter int RECOVER_CYC = `SBP_RECOVER_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins toward the device
    sbp_if.host pins,
    // video timing from the user
    input wire logic userSystemBlankN,
    input wire logic userSystemHsyncN,
    input wire logic userSystemVsyncN,
    input wire logic userLegacyBlankN,
    input wire logic userLegacyHsync,
    input wire logic userLegacyVsync,
    input wire logic [7:0] userLegacyPixel,
    input wire logic [7:0] userSystemPixel,
    input wire logic userSplitFlag,
    input wire logic userWidthSel8,
    // register requests
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [2:0] reqSel,
    input wire logic [7:0] reqData,
    output logic reqReady,
    output logic rspValid,
    output logic [7:0] rspData
);
    import sbp_pkg::*;

    // ------------------------------------------------------------
    // timing pins, registered so they change on clock edges only
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins.systemBlankN <= 1'b1; // [R3]
            pins.systemHsyncN <= 1'b1; // [R5]
            pins.systemVsyncN <= 1'b1;
            pins.legacyBlankN <= 1'b1; // [R4]
            pins.legacyHsyncIn <= 1'b0;
            pins.legacyVsyncIn <= 1'b0;
            pins.legacyPixelBus <= 8'h00;
            pins.systemPixelBus <= 8'h00;
            pins.splitTransferFlag <= 1'b0;
            pins.widthSel8 <= 1'b1;
        end else begin
            pins.systemBlankN <= userSystemBlankN;
            pins.systemHsyncN <= userSystemHsyncN;
            pins.systemVsyncN <= userSystemVsyncN;
            pins.legacyBlankN <= userLegacyBlankN;
            pins.legacyHsyncIn <= userLegacyHsync;
            pins.legacyVsyncIn <= userLegacyVsync;
            pins.legacyPixelBus <= userLegacyPixel;
            pins.systemPixelBus <= userSystemPixel;
            pins.splitTransferFlag <= userSplitFlag;
            pins.widthSel8 <= userWidthSel8;
        end
    end

    // ------------------------------------------------------------
    // strobe sequencer
    // ------------------------------------------------------------
    sbp_state_e state_q;
    logic [7:0] cnt_q;
    logic write_q;
    wire cntDone = cnt_q == 8'h00;
    assign reqReady = state_q == SBP_IDLE;

    // setup holds select and data a cycle before the strobe falls
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SBP_IDLE;
            cnt_q <= 8'h00;
            write_q <= 1'b0;
            pins.wrN <= 1'b1;
            pins.rdN <= 1'b1;
            pins.regSel <= 3'h0;
            pins.hostData <= 8'h00;
            pins.hostDataOe <= 1'b0;
            rspValid <= 1'b0;
            rspData <= 8'h00;
        end else begin
            rspValid <= 1'b0;
            case (state_q)
                SBP_IDLE: begin
                    if (reqValid) begin
                        write_q <= reqWrite;
                        pins.regSel <= reqSel;
                        pins.hostData <= reqData;
                        pins.hostDataOe <= reqWrite;
                        state_q <= SBP_SETUP;
                    end
                end
                SBP_SETUP: begin
                    pins.wrN <= ~write_q; // [R10]
                    pins.rdN <= write_q; // [R16]
                    cnt_q <= 8'(STROBE_CYC - 1);
                    state_q <= SBP_STROBE;
                end
                SBP_STROBE: begin
                    if (cntDone) begin
                        pins.wrN <= 1'b1;
                        pins.rdN <= 1'b1;
                        rspValid <= ~write_q;
                        rspData <= pins.dataBus;
                        cnt_q <= 8'(RECOVER_CYC - 1);
                        state_q <= SBP_RECOVER;
                    end else begin
                        cnt_q <= 8'(cnt_q - 8'h01);
                    end
                end
                SBP_RECOVER: begin
                    // data stays driven past the strobe so the device sees it settled
                    pins.hostDataOe <= 1'b0;
                    if (cntDone) state_q <= SBP_IDLE;
                    else cnt_q <= 8'(cnt_q - 8'h01);
                end
                default: state_q <= SBP_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// ==== design/sbp_if.sv ====
// pin bundle between the graphics controller end and the palette front end
// assumes the testbench joins the two ends through one instance of it
`default_nettype none

interface sbp_if;
    // video timing pins
    logic systemBlankN;
    logic systemHsyncN;
    logic systemVsyncN;
    logic legacyBlankN;
    logic legacyHsyncIn;
    logic legacyVsyncIn;
    logic [7:0] legacyPixelBus;
    logic [7:0] systemPixelBus;
    logic splitTransferFlag;
    // host port pins
    logic wrN;
    logic rdN;
    logic [2:0] regSel;
    logic widthSel8;
    logic [7:0] hostData;
    logic hostDataOe;
    logic [7:0] devData;
    logic devDataOe;
    logic [7:0] dataBus;
    // device outputs
    logic horizSyncPipelined;
    logic vertSyncPipelined;
    logic shiftClockOut;
    logic refClockOut;
    logic videoClockOut;

    // shared data wire resolved from the enables; the device wins a clash
    assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : 8'h00);

    modport dev (
        input systemBlankN, systemHsyncN, systemVsyncN, legacyBlankN,
        input legacyHsyncIn, legacyVsyncIn, legacyPixelBus, systemPixelBus,
        input splitTransferFlag, wrN, rdN, regSel, widthSel8, dataBus,
        output devData, devDataOe, horizSyncPipelined, vertSyncPipelined,
        output shiftClockOut, refClockOut, videoClockOut
    );

    modport host (
        output systemBlankN, systemHsyncN, systemVsyncN, legacyBlankN,
        output legacyHsyncIn, legacyVsyncIn, legacyPixelBus, systemPixelBus,
        output splitTransferFlag, wrN, rdN, regSel, widthSel8, hostData, hostDataOe,
        input dataBus, horizSyncPipelined, vertSyncPipelined,
        input shiftClockOut, refClockOut, videoClockOut
    );
endinterface

`default_nettype wire

// ==== design/sbp_pkg.sv ====
// types shared by both ends of the sync, blank and data-width front end
// assumes nothing beyond the defines header
`default_nettype none

package sbp_pkg;
    // one pipeline slot: blank, both syncs, green sync and pixel travel together
    typedef struct packed {
        logic blank;
        logic hsync;
        logic vsync;
        logic greenSync;
        logic [7:0] pixel;
    } sbp_stage_s;

    // host strobe sequencer, Gray coded along idle, setup, strobe, recover
    typedef enum logic [1:0] {
        SBP_IDLE = 2'b00,
        SBP_SETUP = 2'b01,
        SBP_STROBE = 2'b11,
        SBP_RECOVER = 2'b10
    } sbp_state_e;
endpackage

`default_nettype wire

// ==== tb/sbp_checker.sv ====
// assertions on the pins between the controller end and the palette front end
// assumes the bench keeps the blank input of the unselected source high
`default_nettype none

module sbp_checker #(
    parameter int PIPE_STAGES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // video pins
    input wire logic legacyBlankN,
    input wire logic systemBlankN,
    input wire logic splitTransferFlag,
    input wire logic shiftClockOut,
    input wire logic blankOut,
    // host port pins
    input wire logic wrN,
    input wire logic rdN,
    input wire logic [7:0] hostData,
    input wire logic hostDataOe,
    input wire logic devDataOe
);
    import sbp_pkg::*;
    logic [3:0] blankRun_q;
    logic [3:0] blankRun_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // blank length, saturating: the shift gate settles only after a full divider period
    assign blankRun_d = !blankOut ? 4'h0 : (blankRun_q == 4'hf ? 4'hf : blankRun_q + 4'h1);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blankRun_q <= 4'h0;
        end else begin
            blankRun_q <= blankRun_d;
        end
    end

    // ------------
    // assertions
    // ------------
    sequence readDrive;
        ##[2:4] devDataOe;
    endsequence
    sequence earlyShift;
        ##[1:4] shiftClockOut;
    endsequence
    blank_follow_a: assert property (
        blankOut == !($past(legacyBlankN, PIPE_STAGES) && $past(systemBlankN, PIPE_STAGES)))
        else $error("blank out of step");
    read_drive_a: assert property (
        $fell(rdN) |-> readDrive) else $error("read data not driven");
    read_cause_a: assert property (
        $rose(devDataOe) |-> !rdN && $past(rdN, 2) == 1'b0) else $error("drive without read");
    bus_clash_a: assert property (
        devDataOe |-> !hostDataOe) else $error("both ends drive data");
    write_width_a: assert property (
        $fell(wrN) |-> (!wrN && hostDataOe) [*3]) else $error("write strobe too short");
    write_data_a: assert property (
        !wrN && !$past(wrN) |-> $stable(hostData)) else $error("write data moved");
    split_pulse_a: assert property (
        $rose(splitTransferFlag) && blankRun_q > 4'h9 |-> earlyShift)
        else $error("no early shift pulse");
    shift_gate_a: assert property (
        blankRun_q > 4'h9 && !splitTransferFlag |-> !shiftClockOut)
        else $error("shift clock not gated");
endmodule

`default_nettype wire

// ==== tb/sync_blank_path_and_dac_width_test.sv ====
// bench: both ends joined by one interface, random video and host traffic
// assumes the design files and the checker are compiled first
`include "sbp_defines.svh"
`default_nettype none

module sync_blank_path_and_dac_width_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sbp_pkg::*;
    logic clk, resetn, lb, lhs, lvs, sb, shs, svs, sf, w8, rv, rw, rr, rsv, bo, gs, v;
    logic [2:0] rs;
    logic [7:0] lp, sp, rdat, rsd, dac, got, gc, mk, d;
    logic [21:0] h[0:63];
    int err_total, n_compared, n;
    sbp_if bus();
    sbp_device sbp_device_inst (.clk(clk), .resetn(resetn), .pins(bus), .blankOut(bo),
        .greenSyncOut(gs), .dacData(dac));
    sbp_host sbp_host_inst (.clk(clk), .resetn(resetn), .pins(bus), .userSystemBlankN(sb),
        .userSystemHsyncN(shs), .userSystemVsyncN(svs), .userLegacyBlankN(lb),
        .userLegacyHsync(lhs), .userLegacyVsync(lvs), .userLegacyPixel(lp),
        .userSystemPixel(sp), .userSplitFlag(sf), .userWidthSel8(w8), .reqValid(rv),
        .reqWrite(rw), .reqSel(rs), .reqData(rdat), .reqReady(rr), .rspValid(rsv),
        .rspData(rsd));
    sbp_checker #(.PIPE_STAGES(`SBP_PIPE_STAGES)) sbp_checker_inst (.clk(clk),
        .resetn(resetn), .legacyBlankN(bus.legacyBlankN), .systemBlankN(bus.systemBlankN),
        .splitTransferFlag(bus.splitTransferFlag), .shiftClockOut(bus.shiftClockOut),
        .blankOut(bo), .wrN(bus.wrN), .rdN(bus.rdN), .hostData(bus.hostData),
        .hostDataOe(bus.hostDataOe), .devDataOe(bus.devDataOe));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------
    // checks, verdict and host cycles
    // ------------
    task automatic complete_run();
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // bounded wait at falling edges for ready or for the read answer pulse
    task automatic waitSig(input bit useRsp);
        for (int i = 0; (useRsp ? rsv : rr) !== 1'b1; i++) begin
            if (i > 99) begin
                err_total++;
                complete_run();
            end
            @(negedge clk);
        end
    endtask
    task automatic acc(input logic w, input logic [2:0] s, input logic [7:0] dat);
        waitSig(1'b0);
        {rv, rw, rs, rdat} = {1'b1, w, s, dat};
        @(negedge clk);
        rv = 1'b0;
        if (!w) begin
            waitSig(1'b1);
            got = rsd;
        end
        waitSig(1'b0);
    endtask
    task automatic idxAcc(input logic w, input logic [7:0] i, input logic [7:0] dat);
        acc(1'b1, `SBP_RS_INDEX, i);
        acc(w, `SBP_RS_DATA, dat);
    endtask

    // expected {blank, hsync, vsync, green sync, dac byte} for one input sample
    function automatic logic [11:0] expv(input logic [21:0] x);
        logic [7:0] p;
        p = (gc[3] ? x[7:0] : x[15:8]) & mk;
        p = w8 ? p : {p[5:0], 2'b00};
        if (gc[3]) begin
            return {~x[18], x[17] ^ gc[0], x[16] ^ gc[1], ~x[17] | ~x[16], p};
        end
        return {~x[21], x[20], x[19], (x[20] == gc[2]) | (x[19] == gc[2]), p};
    endfunction
    // random video; the unselected blank stays high so the checker sees one source
    task automatic video(input int cnt);
        logic [11:0] e;
        for (int i = 0; i < cnt; i++) begin
            if (i >= 6) begin
                e = expv(h[i - 5]);
                chk({4'h0, bo, bus.horizSyncPipelined, bus.vertSyncPipelined, gs},
                    {4'h0, e[11:8]});
                e = expv(h[i - 6]);
                chk(dac, e[7:0]);
            end
            h[i] = 22'($urandom) | (gc[3] ? 22'h200000 : 22'h040000);
            {lb, lhs, lvs, sb, shs, svs, lp, sp} = h[i];
            @(negedge clk);
        end
        {lb, sb} = 2'b11;
    endtask

    // ------------
    // main sequence
    // ------------
    initial begin
        err_total = 0;
        n_compared = 0;
        {resetn, rv, rw, rs, rdat, sf, lp, sp} = '0;
        {lb, lhs, lvs, sb, shs, svs, w8, gc, mk} = {7'h7f, 8'h20, 8'hff};
        void'($urandom(91375));
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        // legacy defaults, reset values and an unmapped select
        video(40);
        acc(1'b0, `SBP_RS_MASK, 8'h00);
        chk(got, `SBP_RST_MASK);
        idxAcc(1'b0, `SBP_IDX_GEN_CTRL, 8'h00);
        chk(got, `SBP_RST_GEN_CTRL);
        acc(1'b0, 3'h4, 8'h00);
        chk(got, 8'h00);
        // the holding byte stays whole while the width changes
        d = 8'($urandom);
        acc(1'b1, `SBP_RS_HOLD, d);
        acc(1'b0, `SBP_RS_HOLD, 8'h00);
        chk(got, d);
        w8 = 1'b0;
        acc(1'b0, `SBP_RS_HOLD, 8'h00);
        chk(got, {2'b00, d[5:0]});
        mk = 8'($urandom);
        acc(1'b1, `SBP_RS_MASK, mk);
        video(30);
        w8 = 1'b1;
        acc(1'b0, `SBP_RS_HOLD, 8'h00);
        chk(got, d);
        // every system polarity setting, then legacy with high green sync
        for (int k = 0; k < 9; k++) begin
            gc = (k == 8) ? 8'h24 : 8'h28 | 8'(k);
            idxAcc(1'b1, `SBP_IDX_GEN_CTRL, gc);
            video(14);
        end
        // video clock selections
        for (int c = 0; c < 4; c++) begin
            idxAcc(1'b1, `SBP_IDX_OUT_CLK, {3'h0, 2'(c), 3'h2});
            repeat (8) begin
                v = bus.videoClockOut;
                @(negedge clk);
                chk({7'h0, bus.videoClockOut},
                    {7'h0, c == 1 ? ~v : c == 0 && bus.shiftClockOut});
            end
        end
        // long blank: reference keeps running, shift gated, then the early pulse
        lb = 1'b0;
        repeat (20) @(negedge clk);
        n = 0;
        repeat (16) begin
            @(negedge clk);
            n = n + (bus.refClockOut ? 16 : 0) + (bus.shiftClockOut ? 1 : 0);
        end
        chk(8'(n), 8'h80);
        sf = 1'b1;
        n = 0;
        repeat (6) @(negedge clk) n += bus.shiftClockOut;
        chk({7'h0, n != 0}, 8'h01);
        {lb, sf} = 2'b10;
        n = 0;
        repeat (13) @(negedge clk) n += bus.shiftClockOut;
        chk(8'(n), 8'h00);
        complete_run();
    end
endmodule

`default_nettype wire
